// ===== hw/ccx_exec.sv
// carry complement and register clear executor with wishbone register access
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "ccx_params.svh"

module ccx_exec
  import ccx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [10:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core status
  output logic busy_o,
  output logic carry_o
);

  // ==========================================================================
  // declarations
  logic [7:0] regs_q [0:`CCX_REG_COUNT-1];
  logic ack_q;
  logic [31:0] dat_q;
  ccx_state_t state_q;
  ccx_kind_t kind_q;
  logic [7:0] operand_q;
  logic [7:0] dst_q;
  logic [7:0] wdata_q;
  logic busy_q;
  logic illegal_q;
  logic refused_q;
  logic [1:0] last_bytes_q;
  logic [2:0] last_cycles_q;
  logic [7:0] done_cnt_q;
  logic dec_legal;
  ccx_kind_t dec_kind;
  logic [1:0] dec_bytes;
  logic [2:0] dec_cycles;
  logic [8:0] bus_idx;
  logic bus_req;
  logic bus_wr;
  logic instr_wr;
  logic start;
  logic [7:0] flags_w;

  // ==========================================================================
  // bus decode; a write commits on the edge where the master sees ack
  assign bus_idx = wb_adr_i[10:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & ack_q;
  assign instr_wr = bus_wr && (bus_idx == `CCX_INSTR_IDX) && (wb_sel_i[1:0] == 2'b11);
  assign start = instr_wr && dec_legal && (state_q == CCX_ST_IDLE);
  assign flags_w = regs_q[`CCX_FLAGS_IDX];

  // outputs straight from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign busy_o = busy_q;
  assign carry_o = regs_q[`CCX_FLAGS_IDX][`CCX_CARRY_BIT];

  // instruction byte decoded straight off the write data
  ccx_decode u_decode (
    .opcode_i(wb_dat_i[7:0]),
    .legal_o(dec_legal),
    .kind_o(dec_kind),
    .bytes_o(dec_bytes),
    .cycles_o(dec_cycles)
  );

  // ==========================================================================
  // read mux: register file, instruction echo, status; unmapped reads zero
  function automatic logic [31:0] read_word(input logic [8:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx < 9'h100) begin
      w[7:0] = regs_q[idx[7:0]];
    end else if (idx == `CCX_INSTR_IDX) begin
      w[15:8] = operand_q;
      w[17:16] = kind_q;
    end else if (idx == `CCX_STATUS_IDX) begin
      w[`CCX_ST_BUSY_BIT] = busy_q;
      w[`CCX_ST_ILLEGAL_BIT] = illegal_q;
      w[`CCX_ST_REFUSED_BIT] = refused_q;
      w[5:4] = last_bytes_q;
      w[10:8] = last_cycles_q;
      w[23:16] = done_cnt_q;
    end
    return w;
  endfunction : read_word

  // ==========================================================================
  // wishbone handshake: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // read data captured as ack rises, held while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (bus_req & ~ack_q) begin
      dat_q <= read_word(bus_idx);
    end
  end

  // ==========================================================================
  // sequencer: fetch, address resolve, execute, write back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CCX_ST_IDLE;
      kind_q <= CCX_K_NONE;
      operand_q <= 8'h00;
      dst_q <= 8'h00;
      wdata_q <= 8'h00;
    end else begin
      case (state_q)
        CCX_ST_IDLE: begin
          if (start) begin
            state_q <= CCX_ST_FETCH;
            kind_q <= dec_kind;
            operand_q <= (dec_bytes == `CCX_BYTES_CARRY) ? 8'h00 : wb_dat_i[15:8];
          end
        end
        CCX_ST_FETCH: begin
          state_q <= CCX_ST_ADDR;
        end
        CCX_ST_ADDR: begin
          // indirect form reads the pointer; the pointer is written only when it holds its own index
          if (kind_q == CCX_K_CARRY) begin
            dst_q <= `CCX_FLAGS_IDX;
          end else if (kind_q == CCX_K_ZERO_IND) begin
            dst_q <= regs_q[operand_q];
          end else begin
            dst_q <= operand_q;
          end
          state_q <= CCX_ST_EXEC;
        end
        CCX_ST_EXEC: begin
          if (kind_q == CCX_K_CARRY) begin
            // only the carry bit is flipped, the other flags ride through
            wdata_q <= regs_q[dst_q] ^ (8'h01 << `CCX_CARRY_BIT);
          end else begin
            wdata_q <= `CCX_CLEAR_VAL;
          end
          state_q <= CCX_ST_WRITE;
        end
        CCX_ST_WRITE: begin
          state_q <= CCX_ST_IDLE;
        end
        default: begin
          state_q <= CCX_ST_IDLE;
        end
      endcase
    end
  end

  // busy spans exactly fetch through write back, four cycles for every form
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else if (state_q == CCX_ST_IDLE) begin
      busy_q <= start;
    end else begin
      busy_q <= (state_q != CCX_ST_WRITE);
    end
  end

  // ==========================================================================
  // register file; bus writes are refused while busy so the core owns it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `CCX_REG_COUNT; i++) begin
        regs_q[i] <= (i == `CCX_FLAGS_IDX) ? `CCX_FLAGS_RESET : `CCX_REG_RESET;
      end
    end else if (state_q == CCX_ST_WRITE) begin
      // clear only touches its destination, so flags change only if named
      regs_q[dst_q] <= wdata_q;
    end else if (bus_wr && (bus_idx < 9'h100) && wb_sel_i[0] && !busy_q) begin
      regs_q[bus_idx[7:0]] <= wb_dat_i[7:0];
    end
  end

  // ==========================================================================
  // status: sticky errors, set wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      illegal_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      illegal_q <= (instr_wr && !dec_legal) ||
                   (illegal_q && !(bus_wr && (bus_idx == `CCX_STATUS_IDX) && wb_sel_i[0] &&
                                   wb_dat_i[`CCX_ST_ILLEGAL_BIT]));
      refused_q <= (instr_wr && dec_legal && (state_q != CCX_ST_IDLE)) ||
                   (refused_q && !(bus_wr && (bus_idx == `CCX_STATUS_IDX) && wb_sel_i[0] &&
                                   wb_dat_i[`CCX_ST_REFUSED_BIT]));
    end
  end

  // last accepted instruction length and timing, and a completion counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_bytes_q <= 2'h0;
      last_cycles_q <= 3'h0;
      done_cnt_q <= 8'h00;
    end else begin
      if (start) begin
        last_bytes_q <= dec_bytes;
        last_cycles_q <= dec_cycles;
      end
      if (state_q == CCX_ST_WRITE) begin
        done_cnt_q <= done_cnt_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // checks
  AST_CARRY_INVERT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_EXEC && kind_q == CCX_K_CARRY)
      |-> ##2 (carry_o == !$past(carry_o, 2)))
    else $error("carry not complemented");

  AST_CARRY_OTHERS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_WRITE && kind_q == CCX_K_CARRY)
      |=> (flags_w[6:0] == $past(flags_w[6:0])))
    else $error("complement carry disturbed another flag");

  AST_CARRY_ONLY: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_WRITE && kind_q == CCX_K_CARRY)
      |-> ((wdata_q ^ regs_q[dst_q]) == 8'h80))
    else $error("complement carry write differs from flags beyond carry");

  AST_FOUR_CYCLES: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(busy_q) |-> busy_q [*4] ##1 !busy_q)
    else $error("instruction did not take four cycles");

  AST_BUSY_START: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start |=> (busy_q && state_q == CCX_ST_FETCH))
    else $error("accepted instruction did not start");

  AST_CARRY_LEN: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (start && dec_kind == CCX_K_CARRY) |=> (last_bytes_q == 2'h1 && last_cycles_q == 3'h4))
    else $error("complement carry length or timing wrong");

  AST_FLAGS_HOME: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_WRITE && kind_q == CCX_K_CARRY) |-> (dst_q == 8'hD5))
    else $error("carry written outside flags register");

  AST_ZERO_DIRECT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_WRITE && kind_q == CCX_K_ZERO_DIR)
      |-> (dst_q == operand_q) ##1 (regs_q[$past(dst_q)] == 8'h00))
    else $error("direct clear missed its register");

  AST_ZERO_DATA: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_WRITE && kind_q != CCX_K_CARRY) |-> (wdata_q == 8'h00))
    else $error("clear wrote a nonzero value");

  AST_ZERO_INDIRECT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_ADDR && kind_q == CCX_K_ZERO_IND)
      |=> (dst_q == $past(regs_q[operand_q])) ##2 (regs_q[dst_q] == 8'h00))
    else $error("indirect clear missed the pointed register");

  AST_ZERO_PTR: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_WRITE && kind_q == CCX_K_ZERO_IND && dst_q != operand_q)
      |=> (regs_q[operand_q] == $past(regs_q[operand_q])))
    else $error("indirect clear changed its pointer");

  AST_ZERO_FLAGS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == CCX_ST_WRITE && kind_q != CCX_K_CARRY && dst_q != 8'hD5)
      |=> $stable(flags_w))
    else $error("clear modified the flags");

  AST_ACK_LATENCY: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_req && !ack_q) |=> ack_q)
    else $error("request not acknowledged after one cycle");

  AST_ACK_ONE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(ack_q) |=> !ack_q)
    else $error("ack held longer than one cycle");

endmodule : ccx_exec

// ===== hw/ccx_params.svh
// offsets, field positions, encodings and cycle counts of the carry/clear executor
`ifndef CCX_PARAMS_SVH
`define CCX_PARAMS_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define CCX_REG_COUNT 256
`define CCX_FLAGS_IDX 8'hD5
`define CCX_INSTR_IDX 9'h100
`define CCX_STATUS_IDX 9'h101
`define CCX_FLAGS_RESET 8'h00
`define CCX_REG_RESET 8'h00

// ==========================================================================
// field positions
`define CCX_CARRY_BIT 7
`define CCX_ST_BUSY_BIT 0
`define CCX_ST_ILLEGAL_BIT 1
`define CCX_ST_REFUSED_BIT 2

// ==========================================================================
// opcodes, lengths and timing
`define CCX_OPC_CARRY 8'hEF
`define CCX_OPC_ZERO_DIR 8'hB0
`define CCX_OPC_ZERO_IND 8'hB1
`define CCX_BYTES_CARRY 2'h1
`define CCX_BYTES_ZERO 2'h2
`define CCX_CYC_CARRY 3'h4
`define CCX_CYC_ZERO 3'h4
`define CCX_CLEAR_VAL 8'h00

`endif

// ===== hw/ccx_pkg.sv
// types shared by the carry/clear executor
package ccx_pkg;

  // ========================================================================
  // decoded operation kinds
  typedef enum logic [1:0] {
    CCX_K_NONE = 2'b00,
    CCX_K_CARRY = 2'b01,
    CCX_K_ZERO_DIR = 2'b10,
    CCX_K_ZERO_IND = 2'b11
  } ccx_kind_t;

  // ========================================================================
  // execution sequencer states
  typedef enum logic [2:0] {
    CCX_ST_IDLE = 3'b000,
    CCX_ST_FETCH = 3'b001,
    CCX_ST_ADDR = 3'b010,
    CCX_ST_EXEC = 3'b011,
    CCX_ST_WRITE = 3'b100
  } ccx_state_t;

endpackage : ccx_pkg

// ===== hw/ccx_decode.sv
// opcode decoder: operation kind, byte count and cycle count
`timescale 1ns/1ps
`include "ccx_params.svh"

module ccx_decode
  import ccx_pkg::*;
(
  // opcode in
  input wire logic [7:0] opcode_i,
  // decode out
  output logic legal_o,
  output ccx_kind_t kind_o,
  output logic [1:0] bytes_o,
  output logic [2:0] cycles_o
);

  // ========================================================================
  // decode table; anything else is reported illegal and never executed
  always_comb begin
    legal_o = 1'b1;
    kind_o = CCX_K_NONE;
    bytes_o = 2'h0;
    cycles_o = 3'h0;
    case (opcode_i)
      `CCX_OPC_CARRY: begin
        kind_o = CCX_K_CARRY;
        bytes_o = `CCX_BYTES_CARRY;
        cycles_o = `CCX_CYC_CARRY;
      end
      `CCX_OPC_ZERO_DIR: begin
        kind_o = CCX_K_ZERO_DIR;
        bytes_o = `CCX_BYTES_ZERO;
        cycles_o = `CCX_CYC_ZERO;
      end
      `CCX_OPC_ZERO_IND: begin
        kind_o = CCX_K_ZERO_IND;
        bytes_o = `CCX_BYTES_ZERO;
        cycles_o = `CCX_CYC_ZERO;
      end
      default: begin
        legal_o = 1'b0;
      end
    endcase
  end

endmodule : ccx_decode

// ===== bench/testbench.sv
// self-checking bench for the carry complement and clear executor
`timescale 1ns/1ps
`include "ccx_params.svh"

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module testbench;
  // ==========================================================================
  // clock, reset and bus drive
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [10:0] wb_adr = 11'h000;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic busy_o;
  logic carry_o;
  logic [31:0] rdat;
  int checked = 0;
  int failures = 0;
  int nb;
  // flags index widened to the bus index width
  localparam logic [8:0] FLAGS_IDX = {1'b0, `CCX_FLAGS_IDX};

  // free-running 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  ccx_exec u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .busy_o(busy_o),
    .carry_o(carry_o)
  );

  // ==========================================================================
  // bus and run helpers
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // one classic cycle; the request holds until ack is seen at a rising edge
  task automatic xfer(input logic we, input logic [8:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) begin
        $display("[ERR] bus ack expected 1 seen %b", wb_ack_o);
        failures++;
        final_report();
      end
    end while (wb_ack_o !== 1'b1);
    // ack and read data are taken as they stood at this edge
    rdat = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    // let the committed write settle before a caller looks at outputs
    #1;
  endtask : xfer

  task automatic rd(input logic [8:0] idx);
    xfer(1'b0, idx, 32'h0000_0000);
  endtask : rd

  task automatic wr(input logic [8:0] idx, input logic [7:0] v);
    xfer(1'b1, idx, {24'h000000, v});
  endtask : wr

  // issue one instruction and count the cycles that busy stands high
  task automatic run_instr(input logic [15:0] w, output int cnt);
    cnt = 0;
    xfer(1'b1, `CCX_INSTR_IDX, {16'h0000, w});
    for (int n = 0; n < 40; n++) begin
      if (busy_o === 1'b1) cnt++;
      else if (cnt > 0) break;
      @(posedge clk_i);
      #1;
    end
    // a busy that never drops is a hang, not a slow instruction
    if (cnt >= 40) begin
      $display("[ERR] busy drop expected 0 seen %b", busy_o);
      failures++;
      final_report();
    end
  endtask : run_instr

  // ==========================================================================
  // scenarios
  // carry, busy, the flags, register 5 and every status field read zero after reset
  task automatic s_reset_values;
    `CHK("reset carry", 1'b0, carry_o)
    `CHK("reset busy", 1'b0, busy_o)
    rd(FLAGS_IDX);
    `CHK("reset flags", 8'h00, rdat[7:0])
    rd(9'h005);
    `CHK("reset reg", 8'h00, rdat[7:0])
    rd(`CCX_STATUS_IDX);
    `CHK("reset status", 32'h0000_0000, rdat)
  endtask : s_reset_values

  task automatic s_flags_home;
    wr(FLAGS_IDX, 8'h80);
    `CHK("carry set via flags", 1'b1, carry_o)
    wr(FLAGS_IDX, 8'h7F);
    `CHK("carry clear via flags", 1'b0, carry_o)
    rd(9'h1FF);
    `CHK("unmapped read", 32'h0000_0000, rdat)
  endtask : s_flags_home

  task automatic s_carry;
    wr(FLAGS_IDX, 8'h55);
    run_instr({8'hAA, `CCX_OPC_CARRY}, nb);
    `CHK("carry busy cycles", int'(`CCX_CYC_CARRY), nb)
    `CHK("carry 0 to 1", 1'b1, carry_o)
    rd(FLAGS_IDX);
    `CHK("carry flags", 8'hD5, rdat[7:0])
    rd(`CCX_STATUS_IDX);
    `CHK("carry byte count", `CCX_BYTES_CARRY, rdat[5:4])
    `CHK("carry cycle count", `CCX_CYC_CARRY, rdat[10:8])
    run_instr({8'h00, `CCX_OPC_CARRY}, nb);
    `CHK("carry 1 to 0", 1'b0, carry_o)
    rd(FLAGS_IDX);
    `CHK("carry flags back", 8'h55, rdat[7:0])
    // the opposite pattern in the other flag bits
    wr(FLAGS_IDX, 8'h2A);
    run_instr({8'h00, `CCX_OPC_CARRY}, nb);
    rd(FLAGS_IDX);
    `CHK("carry flags other pattern", 8'hAA, rdat[7:0])
  endtask : s_carry

  task automatic s_zero_dir;
    wr(9'h005, 8'hA5);
    wr(9'h006, 8'h3C);
    wr(FLAGS_IDX, 8'hFF);
    run_instr({8'h05, `CCX_OPC_ZERO_DIR}, nb);
    `CHK("zero busy cycles", int'(`CCX_CYC_ZERO), nb)
    rd(9'h005);
    `CHK("zero target", `CCX_CLEAR_VAL, rdat[7:0])
    rd(9'h006);
    `CHK("zero neighbour", 8'h3C, rdat[7:0])
    rd(FLAGS_IDX);
    `CHK("zero flags", 8'hFF, rdat[7:0])
    rd(`CCX_STATUS_IDX);
    `CHK("zero byte count", `CCX_BYTES_ZERO, rdat[5:4])
  endtask : s_zero_dir

  task automatic s_zero_ind;
    wr(9'h001, 8'h02);
    wr(9'h002, 8'h5E);
    run_instr({8'h01, `CCX_OPC_ZERO_IND}, nb);
    `CHK("zero ind busy cycles", int'(`CCX_CYC_ZERO), nb)
    rd(9'h002);
    `CHK("zero ind target", `CCX_CLEAR_VAL, rdat[7:0])
    rd(9'h001);
    `CHK("zero ind pointer", 8'h02, rdat[7:0])
    rd(FLAGS_IDX);
    `CHK("zero ind flags", 8'hFF, rdat[7:0])
    rd(`CCX_INSTR_IDX);
    `CHK("zero ind operand", 8'h01, rdat[15:8])
    `CHK("zero ind kind", 2'h3, rdat[17:16])
  endtask : s_zero_ind

  // opcodes next to the real ones must not execute as them
  task automatic s_near_opc;
    logic [7:0] opc [3] = '{8'hEE, 8'hF0, 8'hB2};
    wr(9'h005, 8'h77);
    foreach (opc[i]) begin
      run_instr({8'h05, opc[i]}, nb);
      `CHK("stray busy", 0, nb)
      `CHK("stray carry", 1'b1, carry_o)
      rd(9'h005);
      `CHK("stray reg", 8'h77, rdat[7:0])
    end
    rd(`CCX_STATUS_IDX);
    `CHK("illegal flag", 1'b1, rdat[`CCX_ST_ILLEGAL_BIT])
    `CHK("completed count", 8'h05, rdat[23:16])
  endtask : s_near_opc

  // an instruction written while busy is dropped; the illegal and refused bits clear on ones
  task automatic s_refused;
    wr(9'h007, 8'h99);
    xfer(1'b1, `CCX_INSTR_IDX, {16'h0000, 8'h07, `CCX_OPC_ZERO_DIR});
    xfer(1'b1, `CCX_INSTR_IDX, {16'h0000, 8'h00, `CCX_OPC_CARRY});
    rd(`CCX_STATUS_IDX);
    `CHK("refused flag", 1'b1, rdat[`CCX_ST_REFUSED_BIT])
    `CHK("refused busy done", 1'b0, rdat[`CCX_ST_BUSY_BIT])
    `CHK("refused carry kept", 1'b1, carry_o)
    rd(9'h007);
    `CHK("refused first ran", `CCX_CLEAR_VAL, rdat[7:0])
    rd(`CCX_INSTR_IDX);
    `CHK("refused kind kept", 2'h2, rdat[17:16])
    `CHK("refused operand kept", 8'h07, rdat[15:8])
    wr(`CCX_STATUS_IDX, 8'h06);
    rd(`CCX_STATUS_IDX);
    `CHK("status cleared", 3'h0, rdat[2:0])
  endtask : s_refused

  // a second reset in mid-run brings every register back to zero
  task automatic s_mid_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    s_reset_values();
  endtask : s_mid_reset

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset_values();
    s_flags_home();
    s_carry();
    s_zero_dir();
    s_zero_ind();
    s_near_opc();
    s_refused();
    s_mid_reset();
    final_report();
  end
endmodule : testbench
